/* rtl/sfspi_flash_end.sv */
// Device end of the serial flash front end
`timescale 1ns/1ps
module sfspi_flash_end #(
  parameter logic [7:0] NV_INIT = sfspi_pkg::SR1_NV_RESET
) (
  input  wire logic        clk,
  input  wire logic        rst,
  sfspi_if.dev             link,
  output logic [7:0]       statusVol,
  output logic [7:0]       statusNv,
  output logic             writeEnable,
  output logic             volWriteEnable,
  output logic             resetArmed,
  output logic             softResetPulse,
  output logic [15:0]      cycleCount,
  output logic             selected
);

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  logic [1:0] csSync_q;
  logic [1:0] sclkSync_q;
  logic [1:0] mosiSync_q;
  logic       csD_q;
  logic       sclkD_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      csSync_q   <= 2'h3;
      sclkSync_q <= 2'h0;
      mosiSync_q <= 2'h0;
      csD_q      <= 1'b1;
      sclkD_q    <= 1'b0;
    end else begin
      csSync_q   <= {csSync_q[0], link.csN};
      sclkSync_q <= {sclkSync_q[0], link.sclk};
      mosiSync_q <= {mosiSync_q[0], link.mosi};
      csD_q      <= csSync_q[1];
      sclkD_q    <= sclkSync_q[1];
    end
  end

  wire csLow    = ~csSync_q[1];
  wire csFall   = csD_q & csLow;
  wire csRise   = ~csD_q & csSync_q[1];
  wire sclkRise = csLow & sclkSync_q[1] & ~sclkD_q;
  wire sclkFall = csLow & ~sclkSync_q[1] & sclkD_q;

  // ************************************************************
  // Cycle counter
  // ************************************************************
  logic cycleOpen_q;
  logic [15:0] cycleCnt_q;

  always_ff @(posedge clk) begin
    if (rst || csFall) begin
      cycleCnt_q  <= 16'h0000;
      cycleOpen_q <= ~sclkSync_q[1];
    end else if (sclkFall) begin
      cycleCnt_q  <= cycleOpen_q ? cycleCnt_q + 16'h0001 : cycleCnt_q;
      cycleOpen_q <= 1'b1;
    end
  end

  // ************************************************************
  // Parameter table lookup
  // ************************************************************
  function automatic logic [7:0] paramByte(input logic [23:0] a);
    logic [23:0] off;
    off = a - sfspi_pkg::PARAM_DW16_ADDR;
    if (a >= sfspi_pkg::PARAM_DW16_ADDR && off < 24'h000004) begin
      paramByte = sfspi_pkg::PARAM_DW16[off[1:0]*8 +: 8];
    end else begin
      paramByte = sfspi_pkg::PARAM_FILL;
    end
  endfunction

  // ************************************************************
  // Byte assembly and command sequencing
  // ************************************************************
  sfspi_pkg::sfspi_dev_state_t state_q;
  logic [7:0]  rxSh_q;
  logic [2:0]  bitCnt_q;
  logic [2:0]  byteIdx_q;
  logic [7:0]  opcode_q;
  logic [7:0]  data_q;
  logic [23:0] addr_q;
  logic [7:0]  txSh_q;
  logic [2:0]  outCnt_q;
  logic [7:0]  volSr_q;
  logic [7:0]  nvSr_q;

  wire [7:0]  inByte   = {rxSh_q[6:0], mosiSync_q[1]};
  wire        byteDone = sclkRise & (bitCnt_q == 3'h7);
  wire [23:0] addrNext = {addr_q[15:0], inByte};
  wire [23:0] addrInc  = addr_q + 24'h000001;
  wire        isStatus = opcode_q == sfspi_pkg::OP_READ_STATUS;
  wire [7:0]  nextOut  = isStatus ? volSr_q : paramByte(addrInc);

  always_ff @(posedge clk) begin
    if (rst || csFall || csRise) begin
      rxSh_q    <= 8'h00;
      bitCnt_q  <= 3'h0;
      byteIdx_q <= 3'h0;
    end else if (sclkRise) begin
      rxSh_q    <= inByte;
      bitCnt_q  <= bitCnt_q + 3'h1;
      byteIdx_q <= (byteDone && byteIdx_q != 3'h7) ? byteIdx_q + 3'h1 : byteIdx_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || csFall || csRise) begin
      state_q <= sfspi_pkg::DEV_OPCODE;
    end else if (byteDone) begin
      case (state_q)
        sfspi_pkg::DEV_OPCODE: begin
          case (inByte)
            sfspi_pkg::OP_READ_STATUS:  state_q <= sfspi_pkg::DEV_OUT;
            sfspi_pkg::OP_READ_PARAM:   state_q <= sfspi_pkg::DEV_ADDR;
            sfspi_pkg::OP_WRITE_STATUS: state_q <= sfspi_pkg::DEV_IN;
            default:                    state_q <= sfspi_pkg::DEV_IGNORE;
          endcase
        end
        sfspi_pkg::DEV_ADDR: begin
          if (byteIdx_q == sfspi_pkg::PARAM_ADDR_BYTES) begin
            state_q <= sfspi_pkg::DEV_DUMMY;
          end
        end
        sfspi_pkg::DEV_DUMMY: state_q <= sfspi_pkg::DEV_OUT;
        sfspi_pkg::DEV_IN:    state_q <= sfspi_pkg::DEV_IGNORE;
        default:              state_q <= state_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      opcode_q <= 8'h00;
      data_q   <= 8'h00;
      addr_q   <= 24'h000000;
    end else if (byteDone && state_q == sfspi_pkg::DEV_OPCODE) begin
      opcode_q <= inByte;
    end else if (byteDone && state_q == sfspi_pkg::DEV_ADDR) begin
      addr_q   <= addrNext;
    end else if (byteDone && state_q == sfspi_pkg::DEV_IN) begin
      data_q   <= inByte;
    end else if (sclkFall && state_q == sfspi_pkg::DEV_OUT && outCnt_q == 3'h7) begin
      addr_q   <= addrInc;
    end
  end

  // ************************************************************
  // Serial output, updated on falling edges
  // ************************************************************
  logic misoQ;
  logic misoOeQ;

  always_ff @(posedge clk) begin
    if (rst || csFall) begin
      txSh_q   <= 8'h00;
      outCnt_q <= 3'h0;
    end else if (byteDone && state_q == sfspi_pkg::DEV_OPCODE) begin
      txSh_q   <= volSr_q;
    end else if (byteDone && state_q == sfspi_pkg::DEV_DUMMY) begin
      txSh_q   <= paramByte(addr_q);
    end else if (sclkFall && state_q == sfspi_pkg::DEV_OUT) begin
      txSh_q   <= (outCnt_q == 3'h7) ? nextOut : {txSh_q[6:0], 1'b0};
      outCnt_q <= outCnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || csRise) begin
      misoQ   <= 1'b0;
      misoOeQ <= 1'b0;
    end else if (sclkFall && state_q == sfspi_pkg::DEV_OUT) begin
      misoQ   <= txSh_q[7];
      misoOeQ <= 1'b1;
    end
  end

  assign link.miso   = misoQ;
  assign link.misoOe = misoOeQ;

  // ************************************************************
  // Status and write enables, acted on at deselect
  // ************************************************************
  // Single-byte commands count only when exactly whole bytes were sent
  wire whole    = csRise & (bitCnt_q == 3'h0);
  wire oneByte  = whole & (byteIdx_q == 3'h1);
  wire wrStatus = whole & (byteIdx_q == 3'h2) & (opcode_q == sfspi_pkg::OP_WRITE_STATUS);
  wire doReset  = oneByte & (opcode_q == sfspi_pkg::OP_RESET) & resetArmed;
  logic welQ;
  logic volEnQ;
  logic armQ;
  logic resetPulseQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      nvSr_q  <= NV_INIT;
      volSr_q <= NV_INIT;
    end else if (doReset) begin
      volSr_q <= nvSr_q;
    end else if (wrStatus && welQ) begin
      nvSr_q  <= data_q;
      volSr_q <= data_q;
    end else if (wrStatus && volEnQ) begin
      volSr_q <= data_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || doReset) begin
      welQ   <= 1'b0;
      volEnQ <= 1'b0;
    end else if (oneByte && opcode_q == sfspi_pkg::OP_WRITE_EN) begin
      welQ   <= 1'b1;
    end else if (oneByte && opcode_q == sfspi_pkg::OP_VOL_WRITE_EN) begin
      volEnQ <= 1'b1;
    end else if (wrStatus) begin
      welQ   <= 1'b0;
      volEnQ <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      armQ        <= 1'b0;
      resetPulseQ <= 1'b0;
    end else begin
      resetPulseQ <= doReset;
      if (csRise) begin
        armQ <= oneByte & (opcode_q == sfspi_pkg::OP_RESET_EN);
      end
    end
  end

  // ************************************************************
  // User-side outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      statusVol      <= 8'h00;
      statusNv       <= 8'h00;
      writeEnable    <= 1'b0;
      volWriteEnable <= 1'b0;
      softResetPulse <= 1'b0;
      cycleCount     <= 16'h0000;
      selected       <= 1'b0;
    end else begin
      statusVol      <= volSr_q;
      statusNv       <= nvSr_q;
      writeEnable    <= welQ;
      volWriteEnable <= volEnQ;
      softResetPulse <= resetPulseQ;
      cycleCount     <= cycleCnt_q;
      selected       <= csLow;
    end
  end

  assign resetArmed = armQ;

endmodule

/* pkg/sfspi_pkg.sv */
// Shared constants and state types of the serial flash front end
package sfspi_pkg;

  // ************************************************************
  // Instruction codes
  // ************************************************************
  localparam logic [7:0] OP_WRITE_EN     = 8'h06;
  localparam logic [7:0] OP_VOL_WRITE_EN = 8'h50;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_RESET_EN     = 8'h66;
  localparam logic [7:0] OP_RESET        = 8'h99;
  localparam logic [7:0] OP_READ_PARAM   = 8'h5A;

  // ************************************************************
  // Parameter table contents
  // ************************************************************
  localparam logic [23:0] PARAM_DW16_ADDR  = 24'h000068;
  localparam logic [7:0]  ENTER4B_NONE     = 8'h80;
  localparam logic [23:0] PARAM_DW16_LOW   = 24'hC030E8;
  localparam logic [31:0] PARAM_DW16       = {ENTER4B_NONE, PARAM_DW16_LOW};
  localparam logic [7:0]  PARAM_FILL       = 8'hFF;
  localparam logic [2:0]  PARAM_ADDR_BYTES = 3'h3;

  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic [7:0] SR1_NV_RESET   = 8'h00;
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         SCLK_PERIOD_NS = 160;
  localparam int         SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [5:0] {
    DEV_OPCODE = 6'h01,
    DEV_ADDR   = 6'h02,
    DEV_DUMMY  = 6'h04,
    DEV_OUT    = 6'h08,
    DEV_IN     = 6'h10,
    DEV_IGNORE = 6'h20
  } sfspi_dev_state_t;

  typedef enum logic [3:0] {
    HST_IDLE  = 4'h1,
    HST_SETUP = 4'h2,
    HST_SHIFT = 4'h4,
    HST_HOLD  = 4'h8
  } sfspi_host_state_t;

endpackage

/* pkg/sfspi_if.sv */
// Serial bus between the flash end and its bus master
`timescale 1ns/1ps
interface sfspi_if;
  logic csN;
  logic sclk;
  logic mosi;
  logic miso;
  logic misoOe;

  modport dev (
    input  csN,
    input  sclk,
    input  mosi,
    output miso,
    output misoOe
  );

  modport host (
    output csN,
    output sclk,
    output mosi,
    input  miso,
    input  misoOe
  );
endinterface

/* rtl/sfspi_host_end.sv */
// Bus master end of the serial flash front end
`timescale 1ns/1ps
module sfspi_host_end #(
  parameter int HALF_DIV = sfspi_pkg::SCLK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  sfspi_if.host            link,
  input  wire logic        start,
  input  wire logic        mode3,
  input  wire logic [3:0]  cmdLen,
  input  wire logic [3:0]  rdLen,
  input  wire logic [63:0] txData,
  output logic             busy,
  output logic [7:0]       rxByte,
  output logic             rxValid,
  output logic             done
);

  // ************************************************************
  // Half-period divider and input synchroniser
  // ************************************************************
  sfspi_pkg::sfspi_host_state_t state_q;
  logic [7:0] div_q;
  logic [1:0] misoSync_q;
  wire        tick = (div_q == 8'(HALF_DIV - 1));

  always_ff @(posedge clk) begin
    if (rst || state_q == sfspi_pkg::HST_IDLE || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      misoSync_q <= 2'h0;
    end else begin
      misoSync_q <= {misoSync_q[0], link.miso};
    end
  end

  // ************************************************************
  // Transfer sequencing
  // ************************************************************
  logic        csNQ;
  logic        sclkQ;
  logic [63:0] txSh_q;
  logic [8:0]  edgeCnt_q;
  logic [8:0]  edgeTotal_q;
  logic [7:0]  rise_q;
  logic [7:0]  cmdBits_q;
  logic        idleLvl_q;

  wire [7:0] bitTotal = {1'b0, cmdLen, 3'h0} + {1'b0, rdLen, 3'h0};
  wire       goRise   = ~sclkQ;
  wire       lastEdge = edgeCnt_q == edgeTotal_q - 9'h001;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= sfspi_pkg::HST_IDLE;
    end else begin
      case (state_q)
        sfspi_pkg::HST_IDLE: begin
          if (start && cmdLen != 4'h0) begin
            state_q <= sfspi_pkg::HST_SETUP;
          end
        end
        sfspi_pkg::HST_SETUP: if (tick) state_q <= sfspi_pkg::HST_SHIFT;
        sfspi_pkg::HST_SHIFT: if (tick && lastEdge) state_q <= sfspi_pkg::HST_HOLD;
        sfspi_pkg::HST_HOLD:  if (tick) state_q <= sfspi_pkg::HST_IDLE;
        default:              state_q <= sfspi_pkg::HST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      csNQ        <= 1'b1;
      sclkQ       <= 1'b0;
      idleLvl_q   <= 1'b0;
      txSh_q      <= 64'h0000000000000000;
      edgeCnt_q   <= 9'h000;
      edgeTotal_q <= 9'h000;
      cmdBits_q   <= 8'h00;
    end else if (state_q == sfspi_pkg::HST_IDLE) begin
      sclkQ <= idleLvl_q;
      if (start && cmdLen != 4'h0) begin
        csNQ        <= 1'b0;
        idleLvl_q   <= mode3;
        sclkQ       <= mode3;
        txSh_q      <= txData;
        edgeCnt_q   <= 9'h000;
        edgeTotal_q <= {bitTotal, 1'b0};
        cmdBits_q   <= {1'b0, cmdLen, 3'h0};
      end
    end else if (state_q == sfspi_pkg::HST_SHIFT && tick) begin
      sclkQ     <= ~sclkQ;
      edgeCnt_q <= edgeCnt_q + 9'h001;
      if (!goRise && edgeCnt_q != 9'h000) begin
        txSh_q <= {txSh_q[62:0], 1'b0};
      end
    end else if (state_q == sfspi_pkg::HST_HOLD && tick) begin
      csNQ <= 1'b1;
    end
  end

  // ************************************************************
  // Receive path, sampled on rising edges
  // ************************************************************
  logic [7:0] rxSh_q;
  logic [2:0] rxBits_q;
  logic       doneQ;
  wire        sample = state_q == sfspi_pkg::HST_SHIFT && tick && goRise;
  wire [7:0]  rxNext = {rxSh_q[6:0], misoSync_q[1]};

  always_ff @(posedge clk) begin
    if (rst || state_q == sfspi_pkg::HST_IDLE) begin
      rise_q   <= 8'h00;
      rxSh_q   <= 8'h00;
      rxBits_q <= 3'h0;
    end else if (sample) begin
      rise_q <= rise_q + 8'h01;
      if (rise_q >= cmdBits_q) begin
        rxSh_q   <= rxNext;
        rxBits_q <= rxBits_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxByte  <= 8'h00;
      rxValid <= 1'b0;
      doneQ   <= 1'b0;
      busy    <= 1'b0;
    end else begin
      rxValid <= sample && rise_q >= cmdBits_q && rxBits_q == 3'h7;
      if (sample && rise_q >= cmdBits_q && rxBits_q == 3'h7) begin
        rxByte <= rxNext;
      end
      doneQ <= state_q == sfspi_pkg::HST_HOLD && tick;
      busy  <= state_q != sfspi_pkg::HST_IDLE || (start && cmdLen != 4'h0);
    end
  end

  assign done      = doneQ;
  assign link.csN  = csNQ;
  assign link.sclk = sclkQ;
  assign link.mosi = txSh_q[63];

endmodule

/* dv/sfspi_sva.sv */
// Assertions on the serial link between the flash end and the master end
`timescale 1ns/1ps
module sfspi_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  // ************************************************************
  // Link timing and framing
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Idle clock never moves between frames
  AST_IDLE_CLK: assert property (
    csN && $past(csN) |-> $stable(sclk)) else $error("sclk moved while deselected");
  // Setup and first shift tick each take a half period before the first edge
  AST_FIRST_EDGE: assert property (
    $fell(csN) |-> ##[8:16] $changed(sclk)) else $error("no sclk edge after select");
  // Half period of eight clocks in this bench
  AST_HALF_PERIOD: assert property (
    !csN && $changed(sclk) |=> $stable(sclk) [*7]) else $error("sclk half period short");
  AST_MOSI_ON_LOW: assert property (
    !csN && !$past(csN) && $changed(mosi) |-> !sclk) else $error("mosi moved with sclk high");
  AST_MISO_ON_LOW: assert property (
    !csN && misoOe && $changed(miso) |-> !sclk) else $error("miso moved with sclk high");
  // Master samples on the rise, so miso must hold past it
  AST_MISO_HOLD: assert property (
    !csN && misoOe && $rose(sclk) |-> $stable(miso) [*3]) else $error("miso unstable at rise");
  AST_OE_START: assert property (
    $rose(misoOe) |-> !csN && !sclk) else $error("miso driven outside output phase");
  AST_RELEASE: assert property (
    csN [*6] |-> !misoOe && !miso) else $error("miso still driven after deselect");
endmodule

/* dv/testbench.sv */
// Self-checking bench joining the flash end to the master end
`timescale 1ns/1ps
module testbench;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        clk;
  logic        rst;
  logic        start;
  logic        mode3;
  logic [3:0]  cmdLen;
  logic [3:0]  rdLen;
  logic [63:0] txData;
  logic        busy;
  logic [7:0]  rxByte;
  logic        rxValid;
  logic        done;
  logic [7:0]  statusVol;
  logic [7:0]  statusNv;
  logic        writeEnable;
  logic        volWriteEnable;
  logic        resetArmed;
  logic        softResetPulse;
  logic [15:0] cycleCount;
  logic        selected;
  logic [7:0]  rx[$];
  int          errors;
  int          checks_done;
  int          pulses = 0;

  sfspi_if link ();

  sfspi_flash_end #(.NV_INIT(8'h5C)) sfspi_flash_end_i (
    .clk(clk), .rst(rst), .link(link), .statusVol(statusVol), .statusNv(statusNv),
    .writeEnable(writeEnable), .volWriteEnable(volWriteEnable), .resetArmed(resetArmed),
    .softResetPulse(softResetPulse), .cycleCount(cycleCount), .selected(selected));

  sfspi_host_end sfspi_host_end_i (
    .clk(clk), .rst(rst), .link(link), .start(start), .mode3(mode3), .cmdLen(cmdLen),
    .rdLen(rdLen), .txData(txData), .busy(busy), .rxByte(rxByte), .rxValid(rxValid),
    .done(done));

  sfspi_sva sfspi_sva_i (
    .clk(clk), .rst(rst), .csN(link.csN), .sclk(link.sclk), .mosi(link.mosi),
    .miso(link.miso), .misoOe(link.misoOe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (softResetPulse === 1'b1) pulses++;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One whole frame; gap afterwards lets the device act and resync
  task automatic xfer(input logic m3, input logic [3:0] cl, input logic [3:0] rl,
                      input logic [63:0] td);
    int n;
    rx.delete();
    mode3 = m3;
    cmdLen = cl;
    rdLen = rl;
    txData = td;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      if (rxValid === 1'b1) rx.push_back(rxByte);
      n++;
    end
    chk(n < 4000, 1'b1);
    chk({busy, selected}, 2'h3);
    repeat (6) @(posedge clk);
    #1;
    chk({busy, selected}, 2'h0);
  endtask

  task automatic op(input logic m3, input logic [3:0] cl, input logic [7:0] a,
                    input logic [7:0] b);
    xfer(m3, cl, 4'h0, {a, b, 48'h0});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_status();
    xfer(1'b0, 4'h1, 4'h2, {8'h05, 56'h0});
    chk({rx[0], rx[1]}, 16'h5C5C);
    op(1'b0, 4'h1, 8'h50, 8'h00);
    chk(volWriteEnable, 1'b1);
    op(1'b0, 4'h2, 8'h01, 8'hA4);
    chk({statusVol, statusNv, volWriteEnable}, {8'hA4, 8'h5C, 1'b0});
    op(1'b1, 4'h1, 8'h06, 8'h00);
    chk(writeEnable, 1'b1);
    op(1'b1, 4'h2, 8'h01, 8'h3C);
    chk({statusVol, statusNv, writeEnable}, {8'h3C, 8'h3C, 1'b0});
    // No enable left, so this write must be dropped
    op(1'b0, 4'h2, 8'h01, 8'hF0);
    chk({statusVol, statusNv}, 16'h3C3C);
    xfer(1'b1, 4'h1, 4'h1, {8'h05, 56'h0});
    chk(rx[0], 8'h3C);
  endtask

  task automatic t_refuse();
    // Extra byte after the opcode spoils the frame
    op(1'b0, 4'h2, 8'h06, 8'h00);
    chk(writeEnable, 1'b0);
    op(1'b0, 4'h2, 8'h50, 8'h00);
    chk(volWriteEnable, 1'b0);
  endtask

  task automatic t_reset();
    int p0;
    op(1'b0, 4'h1, 8'h50, 8'h00);
    op(1'b0, 4'h2, 8'h01, 8'hC0);
    op(1'b0, 4'h1, 8'h66, 8'h00);
    chk(resetArmed, 1'b1);
    xfer(1'b0, 4'h1, 4'h1, {8'h05, 56'h0});
    chk(resetArmed, 1'b0);
    p0 = pulses;
    op(1'b0, 4'h1, 8'h99, 8'h00);
    chk({pulses == p0, statusVol}, {1'b1, 8'hC0});
    // No continuous read mode is ever entered, so no exit precedes the pair
    op(1'b1, 4'h1, 8'h66, 8'h00);
    op(1'b1, 4'h1, 8'h99, 8'h00);
    chk({pulses == p0 + 1, statusVol, resetArmed}, {1'b1, 8'h3C, 1'b0});
  endtask

  task automatic t_param(input logic m3);
    logic [47:0] got;
    got = 48'h0;
    // Start one below the dword so both fill bytes around it show
    xfer(m3, 4'h5, 4'h6, {8'h5A, 24'h000067, 8'h00, 24'h0});
    chk(rx.size(), 6);
    foreach (rx[i]) got = {got[39:0], rx[i]};
    chk(got, 48'hFF_E8_30_C0_80_FF);
    chk(got[15:8], 8'h80);
    // 88 bits; mode 3 leaves its first fall uncounted
    chk(cycleCount, m3 ? 16'h0057 : 16'h0058);
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    rst = 1'b1;
    start = 1'b0;
    mode3 = 1'b0;
    cmdLen = 4'h0;
    rdLen = 4'h0;
    txData = 64'h0;
    errors = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    t_status();
    t_refuse();
    t_reset();
    t_param(1'b0);
    t_param(1'b1);
    give_verdict();
  end

  // About 20 frames of at most 1500 clocks each, with margin
  initial begin
    #400000;
    errors++;
    give_verdict();
  end
endmodule
